// *** rtl/pcra_pkg.sv ***
// package: constants, types and register map of the configuration-register access controller
package pcra_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned T_ACCESS_NS   = 70;
  localparam int unsigned ACCESS_CYC    = (T_ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0]  RECOVERY_CYC  = 8'h01;

  // ----------------------------------------------------------------
  // software register map
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_CMD    = 5'h00;
  localparam logic [4:0] OFF_WDATA  = 5'h04;
  localparam logic [4:0] OFF_STATUS = 5'h08;
  localparam logic [4:0] OFF_RDATA  = 5'h0c;
  localparam logic [4:0] OFF_SHADOW = 5'h10;
  localparam logic [4:0] OFF_TIMING = 5'h14;

  localparam int unsigned CMD_METHOD_LSB = 0;
  localparam int unsigned CMD_WRITE_BIT  = 2;
  localparam int unsigned CMD_SEL_LSB    = 3;
  localparam int unsigned CMD_FOLLOW_BIT = 5;
  localparam int unsigned ST_BUSY_BIT    = 0;
  localparam int unsigned ST_ERR_BIT     = 1;
  localparam int unsigned ST_DONE_BIT    = 2;

  localparam logic [1:0] METH_PIN_ASYNC = 2'h0;
  localparam logic [1:0] METH_PIN_SYNC  = 2'h1;
  localparam logic [1:0] METH_SOFT      = 2'h2;

  localparam logic [1:0] SEL_REFRESH = 2'h0;
  localparam logic [1:0] SEL_BUS     = 2'h1;
  localparam logic [1:0] SEL_ID      = 2'h2;

  // ----------------------------------------------------------------
  // device side encodings
  // ----------------------------------------------------------------
  localparam int unsigned REG_CODE_LSB  = 18;
  localparam logic [1:0]  CODE_REFRESH  = 2'h0;
  localparam logic [1:0]  CODE_BUS      = 2'h2;
  localparam logic [1:0]  CODE_ID       = 2'h1;
  localparam logic [15:0] WORD_REFRESH  = 16'h0000;
  localparam logic [15:0] WORD_BUS      = 16'h0001;
  localparam logic [15:0] WORD_ID       = 16'h0002;
  localparam logic [2:0]  SOFT_STEPS    = 3'h4;
  localparam logic [15:0] BUS_CONFIG_RESET = 16'h9d1f;
  localparam int unsigned BC_LAT_LSB    = 11;
  localparam int unsigned BC_WAITPOL_BIT = 10;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_LOAD = 6'h02,
    ST_AACT = 6'h04,
    ST_AREL = 6'h08,
    ST_SADV = 6'h10,
    ST_SLAT = 6'h20
  } pcra_state_t;

  typedef struct packed {
    logic        wr;
    logic        rsel;
    logic        top;
    logic        sync;
    logic        data;
    logic [15:0] val;
  } pcra_op_t;

  typedef struct packed {
    logic ce_n;
    logic av_n;
    logic we_n;
    logic oe_n;
    logic be_n;
    logic rsel;
    logic clk;
  } pcra_ctl_t;

endpackage

// *** rtl/pcra_host.sv ***
// controller that loads and reads the memory's configuration registers through its pins
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - select pin high for registers, low array
// - pin register write value rides address lines
// - address bits 19:18 choose the register
// - array read follows a register access
// - sync write is one word, chip held
// - sync read is one word, chip held
// - wait stretches sync chip-enable low time
// - software load: read, read, write, write
// - software read ends with fourth read
// - software sequence uses the highest address
// - third word selects the register
// - software path works with select pin low
// - registers change only from standby
module pcra_host
  import pcra_pkg::*;
#(
  parameter int unsigned ADDR_W = 23
) (
  // clock and reset
  input  wire logic              mclk_in,
  input  wire logic              rst_b_in,
  // software register port
  input  wire logic [4:0]        reg_addr_in,
  input  wire logic [31:0]       reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [31:0]       reg_rdata_out,
  // memory pins
  output logic                   mem_ce_n_out,
  output logic                   mem_addr_valid_n_out,
  output logic                   mem_we_n_out,
  output logic                   mem_oe_n_out,
  output logic                   mem_low_byte_enable_n_out,
  output logic                   mem_high_byte_enable_n_out,
  output logic                   mem_reg_select_pin_out,
  output logic                   mem_clk_out,
  output logic      [ADDR_W-1:0] mem_addr_out,
  output logic      [15:0]       mem_dq_out,
  output logic                   mem_dq_oe_out,
  input  wire logic [15:0]       mem_dq_in,
  input  wire logic              mem_wait_in
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pcra_state_t       st_q,     st_d;
  pcra_ctl_t         ctl_q,    ctl_d;
  logic [ADDR_W-1:0] addr_q,   addr_d;
  logic [15:0]       dq_q,     dq_d;
  logic              dq_oe_q,  dq_oe_d;
  logic [2:0]        step_q,   step_d;
  logic [7:0]        cnt_q,    cnt_d;
  logic [5:0]        cmd_q,    cmd_d;
  logic [15:0]       wdata_q,  wdata_d;
  logic [15:0]       rdat_q,   rdat_d;
  logic [15:0]       shadow_q, shadow_d;
  logic [7:0]        timing_q, timing_d;
  logic              err_q,    err_d;
  logic              done_q,   done_d;
  logic [31:0]       rbus_q,   rbus_d;

  pcra_op_t          cur;
  logic [1:0]        method;
  logic [1:0]        sel;
  logic [2:0]        total;
  logic              last;
  logic              waiting;
  logic              cmd_wr;
  logic              bad;

  // ----------------------------------------------------------------
  // operation list for each step of a command
  // ----------------------------------------------------------------
  function automatic pcra_op_t op_of(input logic [5:0] cmd, input logic [2:0] step, input logic [15:0] wd);
    logic [1:0] m;
    logic [1:0] s;
    pcra_op_t   o;
    m = cmd[CMD_METHOD_LSB +: 2];
    s = cmd[CMD_SEL_LSB +: 2];
    o = '0;
    if (m == METH_SOFT && step < SOFT_STEPS) begin
      o.top = 1'b1;
      o.wr  = (step == 3'h2) || (step == 3'h3 && cmd[CMD_WRITE_BIT]);
      o.data = (step == 3'h3);
      if (step == 3'h2) begin
        o.val = (s == SEL_BUS) ? WORD_BUS : (s == SEL_ID) ? WORD_ID : WORD_REFRESH;
      end else begin
        o.val = wd;
      end
    end else if (m != METH_SOFT && step == 3'h0) begin
      o.rsel = 1'b1;
      o.wr   = cmd[CMD_WRITE_BIT];
      o.sync = (m == METH_PIN_SYNC);
      o.data = 1'b1;
      o.val  = wd;
    end
    return o;
  endfunction

  always_comb begin
    method  = cmd_q[CMD_METHOD_LSB +: 2];
    sel     = cmd_q[CMD_SEL_LSB +: 2];
    cur     = op_of(cmd_q, step_q, wdata_q);
    total   = ((method == METH_SOFT) ? SOFT_STEPS : 3'h1) + {2'h0, cmd_q[CMD_FOLLOW_BIT]};
    last    = (step_q + 3'h1) >= total;
    waiting = (mem_wait_in == shadow_q[BC_WAITPOL_BIT]);
    cmd_wr  = reg_wr_in && reg_addr_in == OFF_CMD;
    bad     = reg_wdata_in[CMD_METHOD_LSB +: 2] == 2'h3 || reg_wdata_in[CMD_SEL_LSB +: 2] == 2'h3
              || (reg_wdata_in[CMD_WRITE_BIT] && reg_wdata_in[CMD_SEL_LSB +: 2] == SEL_ID);
  end

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  always_comb begin
    st_d     = st_q;
    ctl_d    = ctl_q;
    addr_d   = addr_q;
    dq_d     = dq_q;
    dq_oe_d  = dq_oe_q;
    step_d   = step_q;
    cnt_d    = cnt_q;
    cmd_d    = cmd_q;
    wdata_d  = wdata_q;
    rdat_d   = rdat_q;
    shadow_d = shadow_q;
    timing_d = timing_q;
    err_d    = err_q;
    done_d   = done_q;
    rbus_d   = 32'h0;
    if (reg_wr_in && reg_addr_in == OFF_WDATA) begin
      wdata_d = reg_wdata_in[15:0];
    end
    if (reg_wr_in && reg_addr_in == OFF_TIMING) begin
      timing_d = (reg_wdata_in[7:0] == 8'h00) ? 8'h01 : reg_wdata_in[7:0];
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        OFF_CMD:    rbus_d = {26'h0, cmd_q};
        OFF_WDATA:  rbus_d = {16'h0, wdata_q};
        OFF_STATUS: rbus_d = {29'h0, done_q, err_q, st_q != ST_IDLE};
        OFF_RDATA:  rbus_d = {16'h0, rdat_q};
        OFF_SHADOW: rbus_d = {16'h0, shadow_q};
        OFF_TIMING: rbus_d = {24'h0, timing_q};
        default:    rbus_d = 32'h0;
      endcase
    end
    unique case (st_q)
      ST_IDLE: begin
        ctl_d   = '{ce_n: 1'b1, av_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, be_n: 1'b1, rsel: 1'b0, clk: 1'b0};
        dq_oe_d = 1'b0;
        if (cmd_wr) begin
          err_d  = bad;
          done_d = 1'b0;
          if (!bad) begin
            cmd_d  = reg_wdata_in[5:0];
            step_d = 3'h0;
            st_d   = ST_LOAD;
          end
        end
      end
      ST_LOAD: begin
        addr_d = cur.top ? {ADDR_W{1'b1}} : {ADDR_W{1'b0}};
        if (cur.rsel) begin
          addr_d[15:0] = cur.val;
          addr_d[REG_CODE_LSB +: 2] = (sel == SEL_BUS) ? CODE_BUS : (sel == SEL_ID) ? CODE_ID : CODE_REFRESH;
        end
        dq_d    = cur.val;
        dq_oe_d = cur.wr && !cur.rsel;
        ctl_d   = '{ce_n: 1'b0, av_n: 1'b0, we_n: !cur.wr, oe_n: cur.wr || cur.sync,
                    be_n: 1'b0, rsel: cur.rsel, clk: 1'b0};
        cnt_d   = timing_q;
        st_d    = cur.sync ? ST_SADV : ST_AACT;
      end
      ST_AACT: begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h01) begin
          if (!cur.wr) begin
            rdat_d = mem_dq_in;
          end
          ctl_d = '{ce_n: 1'b1, av_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, be_n: 1'b1, rsel: ctl_q.rsel, clk: 1'b0};
          cnt_d = RECOVERY_CYC;
          st_d  = ST_AREL;
        end
      end
      ST_AREL: begin
        cnt_d   = cnt_q - 8'h01;
        dq_oe_d = 1'b0;
        if (cnt_q == 8'h01) begin
          if (cur.data && sel == SEL_BUS) begin
            shadow_d = cur.wr ? cur.val : rdat_q;
          end
          step_d = step_q + 3'h1;
          if (last) begin
            done_d = 1'b1;
            st_d   = ST_IDLE;
          end else begin
            st_d   = ST_LOAD;
          end
        end
      end
      ST_SADV: begin
        ctl_d.clk = !ctl_q.clk;
        if (ctl_q.clk) begin
          ctl_d.av_n = 1'b1;
          cnt_d = {5'h0, shadow_q[BC_LAT_LSB +: 3]};
          st_d  = ST_SLAT;
        end
      end
      ST_SLAT: begin
        ctl_d.clk = !ctl_q.clk;
        ctl_d.oe_n = cur.wr;
        if (ctl_q.clk && !waiting) begin
          if (cnt_q == 8'h00) begin
            if (!cur.wr) begin
              rdat_d = mem_dq_in;
            end
            ctl_d = '{ce_n: 1'b1, av_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, be_n: 1'b1, rsel: ctl_q.rsel, clk: 1'b0};
            cnt_d = RECOVERY_CYC;
            st_d  = ST_AREL;
          end else begin
            cnt_d = cnt_q - 8'h01;
          end
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!rst_b_in) begin
      st_q     <= ST_IDLE;
      ctl_q    <= '{ce_n: 1'b1, av_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, be_n: 1'b1, rsel: 1'b0, clk: 1'b0};
      addr_q   <= '0;
      dq_q     <= 16'h0;
      dq_oe_q  <= 1'b0;
      step_q   <= 3'h0;
      cnt_q    <= 8'h00;
      cmd_q    <= 6'h00;
      wdata_q  <= 16'h0;
      rdat_q   <= 16'h0;
      shadow_q <= BUS_CONFIG_RESET;
      timing_q <= 8'(ACCESS_CYC);
      err_q    <= 1'b0;
      done_q   <= 1'b0;
      rbus_q   <= 32'h0;
    end else begin
      st_q     <= st_d;
      ctl_q    <= ctl_d;
      addr_q   <= addr_d;
      dq_q     <= dq_d;
      dq_oe_q  <= dq_oe_d;
      step_q   <= step_d;
      cnt_q    <= cnt_d;
      cmd_q    <= cmd_d;
      wdata_q  <= wdata_d;
      rdat_q   <= rdat_d;
      shadow_q <= shadow_d;
      timing_q <= timing_d;
      err_q    <= err_d;
      done_q   <= done_d;
      rbus_q   <= rbus_d;
    end
  end

  assign reg_rdata_out              = rbus_q;
  assign mem_ce_n_out               = ctl_q.ce_n;
  assign mem_addr_valid_n_out       = ctl_q.av_n;
  assign mem_we_n_out               = ctl_q.we_n;
  assign mem_oe_n_out               = ctl_q.oe_n;
  assign mem_low_byte_enable_n_out  = ctl_q.be_n;
  assign mem_high_byte_enable_n_out = ctl_q.be_n;
  assign mem_reg_select_pin_out     = ctl_q.rsel;
  assign mem_clk_out                = ctl_q.clk;
  assign mem_addr_out               = addr_q;
  assign mem_dq_out                 = dq_q;
  assign mem_dq_oe_out              = dq_oe_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_array_select: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (st_q == ST_AACT && !cur.rsel) |-> !mem_reg_select_pin_out) else $error("select pin high on array access");
  chk_value_on_addr: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (st_q == ST_AACT && cur.rsel && cur.wr) |-> (mem_addr_out[15:0] == wdata_q && !mem_dq_oe_out))
    else $error("register write value not on address lines");
  chk_reg_code: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (st_q == ST_AACT && cur.rsel && sel == SEL_BUS) |-> mem_addr_out[19:18] == 2'b10)
    else $error("wrong register code on address bits");
  chk_follow_read: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (st_q == ST_AREL && cur.rsel && cmd_q[CMD_FOLLOW_BIT] && cnt_q == 8'h01)
    |-> ##2 (!mem_ce_n_out && !mem_reg_select_pin_out && !mem_oe_n_out))
    else $error("array read does not follow register access");
  chk_sync_ce_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (st_q == ST_SLAT) |-> (!mem_ce_n_out && mem_addr_valid_n_out)) else $error("chip enable dropped in sync access");
  chk_wait_stretch: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (st_q == ST_SLAT && mem_clk_out && waiting) |=> (st_q == ST_SLAT && $stable(cnt_q)))
    else $error("wait cycle did not extend access");
  chk_soft_order: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (st_q == ST_AACT && method == METH_SOFT && step_q < 3'h2) |-> (mem_we_n_out && !mem_oe_n_out))
    else $error("software sequence does not open with reads");
  chk_soft_addr: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (st_q == ST_AACT && method == METH_SOFT && step_q < SOFT_STEPS)
    |-> (&mem_addr_out && !mem_reg_select_pin_out)) else $error("software step off highest address");
  chk_soft_select: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (st_q == ST_AACT && method == METH_SOFT && step_q == 3'h2 && sel == SEL_BUS)
    |-> (mem_dq_out == 16'h0001 && mem_dq_oe_out && !mem_we_n_out)) else $error("wrong selector word");
  chk_start_idle: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
    (st_q == ST_LOAD && step_q == 3'h0) |-> $past(mem_ce_n_out)) else $error("access started outside standby");

endmodule

`default_nettype wire

// *** verif/pcra_dev_model.sv ***
// behavioural memory device answering configuration register accesses
`timescale 1ns/10ps
`default_nettype none
module pcra_dev_model
  import pcra_pkg::*;
#(
  parameter logic [15:0] DEV_ID = 16'h5a3c  // arbitrary value
) (
  // clock and stimulus
  input  wire logic        mclk_in,
  input  wire logic        rst_b_in,
  input  wire logic [1:0]  stall_in,
  // memory pins
  input  wire logic        ce_n_in,
  input  wire logic        we_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        sel_in,
  input  wire logic        clk_in,
  input  wire logic [22:0] addr_in,
  input  wire logic [15:0] dq_in,
  output logic      [15:0] dq_out,
  output logic             wait_out
);
  logic [15:0] regs_q [4];
  logic        ce_q, we_q, rsel_q, seen_q;
  logic [1:0]  step_q, sel_q, stall_q;
  logic [15:0] last_q, val;
  logic [22:0] bst_q;
  logic [2:0]  lat_q;

  // length codes 1..4 give 4, 8, 16 and 32 word blocks; others run on
  localparam logic [2:0] BL_FIRST = 3'h1;
  localparam logic [2:0] BL_LAST  = 3'h4;

  // next burst address: wrap inside the aligned block or run on linearly
  function automatic logic [22:0] burst_next(input logic [22:0] a, input logic [15:0] bc);
    logic [22:0] blk;
    logic [22:0] inc;
    blk = 23'h0;
    inc = a + 23'h1;
    if (bc[2:0] >= BL_FIRST && bc[2:0] <= BL_LAST) begin
      blk = (23'h4 << (bc[2:0] - BL_FIRST)) - 23'h1;
    end
    if (!bc[3] && blk != 23'h0) begin
      return (a & ~blk) | (inc & blk);
    end
    return inc;
  endfunction

  always_comb begin
    if (sel_in) begin
      val = regs_q[addr_in[19:18]];
    end else if (&addr_in && step_q == 2'h3) begin
      val = regs_q[sel_q];
    end else if (seen_q) begin
      val = bst_q[15:0] ^ 16'h5555;
    end else begin
      val = addr_in[15:0] ^ 16'h5555;
    end
  end
  // released bus shows the inverse of the last word
  assign dq_out   = (!ce_n_in && !oe_n_in) ? val : ~last_q;
  assign wait_out = !ce_n_in && seen_q && stall_q != 2'h0;

  always_ff @(posedge mclk_in) begin
    ce_q <= ce_n_in;
    if (!ce_n_in) begin
      we_q  <= we_n_in;
      rsel_q <= sel_in;
    end
    if (!ce_n_in && !oe_n_in) last_q <= val;
    seen_q <= !ce_n_in && (seen_q || clk_in);
    if (ce_q && !ce_n_in) stall_q <= stall_in;
    else if (clk_in && stall_q != 2'h0) stall_q <= stall_q - 2'h1;
    // burst address steps once the latency has run out, reads and writes alike
    if (ce_q && !ce_n_in) begin
      bst_q <= addr_in;
      lat_q <= regs_q[CODE_BUS][BC_LAT_LSB +: 3];
    end else if (clk_in && !ce_n_in && !wait_out) begin
      if (lat_q != 3'h0) lat_q <= lat_q - 3'h1;
      else bst_q <= burst_next(bst_q, regs_q[CODE_BUS]);
    end
    if (!rst_b_in) begin
      regs_q[CODE_REFRESH] <= 16'h0000;
      regs_q[CODE_ID]      <= DEV_ID;
      regs_q[CODE_BUS]     <= BUS_CONFIG_RESET;
      step_q               <= 2'h0;
    end else if (!ce_q && ce_n_in) begin
      if (rsel_q) begin
        // value rides the address lines, byte enables ignored
        if (!we_q && addr_in[19:18] != CODE_ID) regs_q[addr_in[19:18]] <= addr_in[15:0];
      end else if (!(&addr_in)) begin
        step_q <= 2'h0;
      end else if (step_q < 2'h2) begin
        step_q <= we_q ? step_q + 2'h1 : 2'h0;
      end else if (step_q == 2'h2) begin
        sel_q  <= {dq_in[0], dq_in[1]};
        step_q <= (!we_q && dq_in[15:2] == 14'h0 && dq_in[1:0] != 2'h3) ? 2'h3 : 2'h0;
      end else begin
        if (!we_q && sel_q != CODE_ID) regs_q[sel_q] <= dq_in;
        step_q <= 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

// *** verif/pcra_host_tb_top.sv ***
// self-checking bench of the configuration-register access controller
`timescale 1ns/10ps
`default_nettype none
module pcra_host_tb_top;
  import pcra_pkg::*;
  localparam logic [15:0] DEV_ID = 16'h5a3c;  // arbitrary value
  logic        mclk_in, rst_b_in, reg_wr, reg_rd, chk_rd, chk_d, wt, dq_oe;
  logic        ce_n, av_n, we_n, oe_n, lbe_n, hbe_n, sel, bclk;
  logic [4:0]  reg_addr;
  logic [31:0] reg_wdata, rdata, rd_v, seed, r;
  logic [22:0] addr;
  logic [15:0] dq_o, dq_m, dq_bus, v;
  logic [1:0]  stall;
  logic [31:0] exp_q[$];
  int          bad_count, checked;

  assign dq_bus = dq_oe ? dq_o : dq_m;

  pcra_host pcra_host_inst (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
    .mem_ce_n_out(ce_n), .mem_addr_valid_n_out(av_n), .mem_we_n_out(we_n), .mem_oe_n_out(oe_n),
    .mem_low_byte_enable_n_out(lbe_n), .mem_high_byte_enable_n_out(hbe_n),
    .mem_reg_select_pin_out(sel), .mem_clk_out(bclk), .mem_addr_out(addr), .mem_dq_out(dq_o),
    .mem_dq_oe_out(dq_oe), .mem_dq_in(dq_bus), .mem_wait_in(wt));

  pcra_dev_model #(.DEV_ID(DEV_ID)) pcra_dev_model_inst (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .stall_in(stall), .ce_n_in(ce_n), .we_n_in(we_n), .oe_n_in(oe_n), .sel_in(sel), .clk_in(bclk),
    .addr_in(addr), .dq_in(dq_bus), .dq_out(dq_m), .wait_out(wt));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk_in);
    reg_wr <= 1'b0;
    @(posedge mclk_in);
  endtask

  // read; a checked read leaves its expectation for the monitor
  task automatic rd(input logic [4:0] a, input logic c, input logic [31:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    chk_rd   <= c;
    if (c) exp_q.push_back(e);
    @(posedge mclk_in);
    reg_rd <= 1'b0;
    @(negedge mclk_in);
    rd_v = rdata;
    @(posedge mclk_in);
  endtask

  // issue one command and poll a status bit under a bound
  task automatic run(input int m, input logic w, input int s, input logic f, input int b);
    int n;
    r = rnd();
    stall <= r[1:0];
    wr(OFF_CMD, {26'h0, f, s[1:0], w, m[1:0]});
    n = 0;
    do begin
      rd(OFF_STATUS, 1'b0, 32'h0);
      n++;
    end while (rd_v[b] !== 1'b1 && n < 200);
    if (n >= 200) begin
      bad_count++;
      stop_test();
    end
  endtask

  always @(posedge mclk_in) chk_d <= reg_rd && chk_rd;
  always @(negedge mclk_in) if (chk_d) chk(rdata, exp_q.pop_front());

  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b_in = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    chk_rd = 1'b0;
    stall = 2'h0;
    seed = 32'd70368;
    bad_count = 0;
    checked = 0;
    repeat (12) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    @(posedge mclk_in);
    rd(OFF_SHADOW, 1'b1, 32'h9d1f);
    rd(OFF_TIMING, 1'b1, 32'h0000000e);
    rd(OFF_STATUS, 1'b1, 32'h0);
    rd(5'h18, 1'b1, 32'h0);
    wr(OFF_TIMING, 32'h0);
    rd(OFF_TIMING, 1'b1, 32'h00000001);
    wr(OFF_TIMING, {24'h0, 8'(ACCESS_CYC)});
    run(METH_PIN_ASYNC, 1'b0, SEL_BUS, 1'b0, ST_DONE_BIT);
    rd(OFF_RDATA, 1'b1, {16'h0, BUS_CONFIG_RESET});
    $display("test reset values done");
    for (int s = 0; s < 2; s++) begin
      for (int m = 0; m < 3; m++) begin
        r = rnd();
        // bus config keeps latency 3 and wait active high
        v = (s == 1) ? ((r[15:0] & 16'hc3ff) | 16'h1c00) : r[15:0];
        wr(OFF_WDATA, {16'h0, v});
        run(m, 1'b1, s, m[0], ST_DONE_BIT);
        for (int k = 0; k < 3; k++) begin
          run(k, 1'b0, s, 1'b0, ST_DONE_BIT);
          rd(OFF_RDATA, 1'b1, {16'h0, v});
        end
        if (s == 1) rd(OFF_SHADOW, 1'b1, {16'h0, v});
      end
    end
    $display("test register write and read back done");
    run(METH_PIN_ASYNC, 1'b1, SEL_ID, 1'b0, ST_ERR_BIT);
    rd(OFF_STATUS, 1'b1, 32'h00000002);
    for (int k = 0; k < 3; k++) begin
      run(k, 1'b0, SEL_ID, 1'b0, ST_DONE_BIT);
      rd(OFF_RDATA, 1'b1, {16'h0, DEV_ID});
    end
    run(3, 1'b0, SEL_BUS, 1'b0, ST_ERR_BIT);
    rd(OFF_CMD, 1'b1, {26'h0, 1'b0, SEL_ID, 1'b0, METH_SOFT});
    rd(OFF_WDATA, 1'b1, {16'h0, v});
    $display("test identity register done");
    stop_test();
  end
endmodule
`default_nettype wire
